// [smpc_ctrl.sv]
// Mode, blanking and protection control with a Wishbone register port
`timescale 1ns/1ns
module smpc_ctrl #(
    parameter int unsigned BLANK_CYCLES = smpc_pkg::BLANK_CYC,
    parameter int unsigned LATCH_DLY_CYCLES = smpc_pkg::LATCH_DLY_CYC
) (
    input wire logic clk_sys,                    // 10 MHz time base
    input wire logic nrst,                       // Async reset, active low
    input wire smpc_pkg::smpc_flags_s flags_in,  // Raw comparator flags
    input wire logic wb_cyc_i,                   // Wishbone cycle
    input wire logic wb_stb_i,                   // Wishbone strobe
    input wire logic wb_we_i,                    // Wishbone write
    input wire logic [3:0] wb_adr_i,             // Wishbone byte address
    input wire logic [3:0] wb_sel_i,             // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,            // Wishbone write data
    output logic [31:0] wb_dat_o,                // Wishbone read data
    output logic wb_ack_o,                       // Wishbone acknowledge
    output smpc_pkg::smpc_ctrl_s ctrl_out        // Power stage controls
);
    import smpc_pkg::*;

    localparam int NF = $bits(smpc_flags_s);

    // Counters are 22 bits wide and a limit below two leaves no interval
    if (BLANK_CYCLES < 2 || LATCH_DLY_CYCLES < 2 || BLANK_CYCLES > 32'h003FFFFF || LATCH_DLY_CYCLES > 32'h003FFFFF)
    begin : g_bad_counts
        $error("smpc_ctrl: counts out of range");
    end

    // Three-stage synchronisers; second and third must agree
    logic [NF-1:0] s1_q, s2_q, s3_q, flt_q;
    logic [NF-1:0] flt_d;
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++)
        begin : g_sync
            assign flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end
        else
        begin
            s1_q <= flags_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    smpc_flags_s f;
    assign f = flt_q;

    // Qualification counters: saturate at limit, restart when flag drops
    function automatic logic [21:0] qual_next(input logic cond, input logic [21:0] cnt, input logic [21:0] lim);
        if (!cond)
            qual_next = '0;
        else if (cnt >= lim)
            qual_next = lim;
        else
            qual_next = cnt + 22'h000001;
    endfunction : qual_next

    smpc_mode_e mode_q, mode_d;
    logic [21:0] blank_q, ovp_q, temp_q, short_q, spike_q, dly_q;
    logic [1:0] ctrl_q;
    logic bias_q, cell_q;

    localparam logic [21:0] LIM_BLANK = 22'(BLANK_CYCLES);
    localparam logic [21:0] LIM_OVP = 22'(OVP_CYC);
    localparam logic [21:0] LIM_SPIKE = 22'(SPIKE_CYC);
    localparam logic [21:0] LIM_SHORT = 22'(SHORT_CYC);
    localparam logic [21:0] LIM_DLY = 22'(LATCH_DLY_CYCLES);

    wire in_normal = (mode_q == ST_NORMAL);
    wire in_burst = (mode_q == ST_BURST);
    wire running = in_normal || in_burst;
    // Feedback low counts only in normal; high counts in normal or burst
    wire blank_cond = f.softstart_done && ((in_normal && f.fb_low) || (running && f.fb_high));
    wire [21:0] blank_d = qual_next(blank_cond, blank_q, LIM_BLANK);
    wire blank_done = (blank_q == LIM_BLANK);
    wire burst_enter = in_normal && blank_done && f.fb_low && ctrl_q[CTRL_BURST_EN_BIT];
    wire overload = running && blank_done && f.fb_high;
    // Spike timer runs once clamp is open and pin is charged
    wire spike_cond = (mode_q == ST_AR_WAIT) && f.bl_charged;
    wire [21:0] spike_d = qual_next(spike_cond, spike_q, LIM_SPIKE);
    wire ar_fire = (spike_q == LIM_SPIKE);
    wire [21:0] ovp_d = qual_next(f.vcc_ovp, ovp_q, LIM_OVP);
    wire [21:0] temp_d = qual_next(f.over_temp, temp_q, LIM_SPIKE);
    wire [21:0] short_d = qual_next(f.cs_short, short_q, LIM_SHORT);
    // Ignore window re-arms from the first cycle of start-up or restart
    wire [21:0] dly_d = (mode_d == ST_STARTUP || mode_d == ST_RESTART) ? '0 : qual_next(1'b1, dly_q, LIM_DLY);
    wire ext_latch = f.bl_pulled && (dly_q == LIM_DLY) && ctrl_q[CTRL_LATCH_EN_BIT];
    wire latch_trig = (ovp_q == LIM_OVP) || (temp_q == LIM_SPIKE) || (short_q == LIM_SHORT) || ext_latch;
    wire uv_trig = f.vcc_uv && (running || mode_q == ST_AR_WAIT);

    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            ST_STARTUP, ST_RESTART:
                if (f.softstart_done)
                    mode_d = ST_NORMAL;
            ST_NORMAL:
                if (overload)
                    mode_d = ST_AR_WAIT;
                else if (burst_enter)
                    mode_d = ST_BURST;
            ST_BURST:
                if (overload)
                    mode_d = ST_AR_WAIT;
                else if (f.fb_high)
                    mode_d = ST_NORMAL;
            ST_AR_WAIT:
                if (ar_fire)
                    mode_d = ST_RESTART;
            ST_LATCHED:
                mode_d = ST_LATCHED;
            default:
                mode_d = ST_STARTUP;
        endcase
        if (uv_trig)
            mode_d = ST_RESTART;
        if (latch_trig && mode_q != ST_LATCHED)
            mode_d = ST_LATCHED;
        // Supply reset outranks a latch so the outputs follow the cleared mode
        if (f.vcc_rst)
            mode_d = ST_STARTUP;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_q <= ST_STARTUP;
            blank_q <= '0;
            ovp_q <= '0;
            temp_q <= '0;
            short_q <= '0;
            spike_q <= '0;
            dly_q <= '0;
        end
        else if (f.vcc_rst)
        begin
            mode_q <= ST_STARTUP;
            blank_q <= '0;
            ovp_q <= '0;
            temp_q <= '0;
            short_q <= '0;
            spike_q <= '0;
            dly_q <= '0;
        end
        else
        begin
            mode_q <= mode_d;
            blank_q <= (mode_d != mode_q) ? '0 : blank_d;
            ovp_q <= ovp_d;
            temp_q <= temp_d;
            short_q <= short_d;
            spike_q <= spike_d;
            dly_q <= dly_d;
        end
    end

    // Bias in burst follows wake/sleep hysteresis
    // Leaving burst for any mode but latched restores bias at once instead of keeping an idle phase
    wire burst_stay = in_burst && (mode_d == ST_BURST);
    wire bias_d = burst_stay ? (f.fb_wake ? 1'b1 : (f.fb_sleep ? 1'b0 : bias_q))
                             : (mode_d == ST_BURST ? 1'b0 : (mode_d != ST_LATCHED));
    // Latched off: lockout hysteresis drives the cell
    wire cell_d = (mode_q == ST_LATCHED) ? (f.vcc_uv ? 1'b1 : (f.vcc_on ? 1'b0 : cell_q))
                : (mode_q == ST_STARTUP || mode_q == ST_RESTART) ? !f.vcc_on : 1'b0;
    wire clamp_d = (mode_d == ST_AR_WAIT);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            bias_q <= 1'b0;
            cell_q <= 1'b0;
            ctrl_out <= '0;
        end
        else
        begin
            bias_q <= bias_d;
            cell_q <= cell_d;
            ctrl_out.bias_en <= bias_d;
            ctrl_out.burst_limit_sel <= (mode_d == ST_BURST);
            ctrl_out.blanking_clamp_switch <= !clamp_d;
            ctrl_out.startup_cell_on <= cell_d;
            ctrl_out.switching_en <= (mode_d != ST_LATCHED) && (mode_d != ST_AR_WAIT) && bias_d;
            ctrl_out.burst_flag <= (mode_d == ST_BURST);
            ctrl_out.latched_off <= (mode_d == ST_LATCHED);
            ctrl_out.auto_restart <= (mode_d == ST_RESTART);
        end
    end

    // Wishbone slave: one registered ack per request, a cycle after the strobe
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [31:0] rd_mux = (wb_adr_i == ADDR_CTRL) ? {30'h0, ctrl_q}
                       : (wb_adr_i == ADDR_STAT) ? {11'h0, flt_q, 5'h0, mode_q}
                       : (wb_adr_i == ADDR_ID) ? ID_VALUE : 32'h0;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= rd_mux;
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL)
                ctrl_q <= wb_dat_i[1:0];
        end
    end

    property p_burst_limit;
        @(posedge clk_sys) disable iff (!nrst) (mode_q == ST_BURST) |-> ctrl_out.burst_limit_sel;
    endproperty
    a_burst_limit: assert property (p_burst_limit) else $error("limit not reduced in burst");
    property p_cell_burst;
        @(posedge clk_sys) disable iff (!nrst) (mode_q == ST_BURST) |-> !ctrl_out.startup_cell_on;
    endproperty
    a_cell_burst: assert property (p_cell_burst) else $error("cell on in burst");
    property p_latched_no_sw;
        @(posedge clk_sys) disable iff (!nrst) (mode_q == ST_LATCHED) |-> !ctrl_out.switching_en;
    endproperty
    a_latched_no_sw: assert property (p_latched_no_sw) else $error("switching while latched");
    property p_latch_hold;
        @(posedge clk_sys) disable iff (!nrst) (mode_q == ST_LATCHED && !f.vcc_rst) |=> mode_q == ST_LATCHED;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch left early");
    property p_burst_entry;
        @(posedge clk_sys) disable iff (!nrst) $rose(mode_q == ST_BURST) |-> $past(blank_q) == LIM_BLANK;
    endproperty
    a_burst_entry: assert property (p_burst_entry) else $error("burst without blanking");
    property p_blank_zero;
        @(posedge clk_sys) disable iff (!nrst) (in_normal && !f.fb_low && !f.fb_high) |=> blank_q == 22'h0;
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("blank counter not held");
    property p_ar_spike;
        @(posedge clk_sys) disable iff (!nrst) $rose(mode_q == ST_RESTART) && $past(mode_q) == ST_AR_WAIT && !$past(f.vcc_uv)
            |-> $past(spike_q) == LIM_SPIKE;
    endproperty
    a_ar_spike: assert property (p_ar_spike) else $error("restart before spike time");
    property p_clamp_open;
        @(posedge clk_sys) disable iff (!nrst) (mode_q == ST_AR_WAIT) |-> !ctrl_out.blanking_clamp_switch;
    endproperty
    a_clamp_open: assert property (p_clamp_open) else $error("clamp closed while waiting");

    // Further checks; the first two use single-cycle named sequences
    sequence s_no_softstart;
        !f.softstart_done;
    endsequence
    sequence s_restart_ready;
        mode_q == ST_RESTART && f.softstart_done && !latch_trig && !f.vcc_rst;
    endsequence
    property p_blank_gated;
        @(posedge clk_sys) disable iff (!nrst) s_no_softstart |=> blank_q == 22'h0;
    endproperty
    a_blank_gated: assert property (p_blank_gated) else $error("blanking ran before start-up done");
    property p_restart_resume;
        @(posedge clk_sys) disable iff (!nrst) s_restart_ready |=> mode_q == ST_NORMAL;
    endproperty
    a_restart_resume: assert property (p_restart_resume) else $error("restart did not resume");
    property p_burst_bias_off;
        @(posedge clk_sys) disable iff (!nrst) $rose(mode_q == ST_BURST) |-> !ctrl_out.bias_en && ctrl_out.burst_flag;
    endproperty
    a_burst_bias_off: assert property (p_burst_bias_off) else $error("burst entry kept bias");
    property p_wake_bias;
        @(posedge clk_sys) disable iff (!nrst) burst_stay && f.fb_wake |=> ctrl_out.bias_en;
    endproperty
    a_wake_bias: assert property (p_wake_bias) else $error("bias not restored on wake");
    property p_sleep_bias;
        @(posedge clk_sys) disable iff (!nrst) burst_stay && f.fb_sleep && !f.fb_wake |=> !ctrl_out.bias_en;
    endproperty
    a_sleep_bias: assert property (p_sleep_bias) else $error("bias kept on sleep");
    property p_burst_exit;
        @(posedge clk_sys) disable iff (!nrst) in_burst && f.fb_high && !f.vcc_uv && !latch_trig && !f.vcc_rst
            |=> mode_q == ST_NORMAL && !ctrl_out.burst_limit_sel;
    endproperty
    a_burst_exit: assert property (p_burst_exit) else $error("burst not left on high feedback");
    property p_latch_entry;
        @(posedge clk_sys) disable iff (!nrst) mode_q != ST_LATCHED && latch_trig && !f.vcc_rst |=> mode_q == ST_LATCHED;
    endproperty
    a_latch_entry: assert property (p_latch_entry) else $error("latch cause ignored");
    property p_short_latch;
        @(posedge clk_sys) disable iff (!nrst) short_q == LIM_SHORT && !f.vcc_rst |=> mode_q == ST_LATCHED;
    endproperty
    a_short_latch: assert property (p_short_latch) else $error("short winding not latched");
    property p_ovp_restart;
        @(posedge clk_sys) disable iff (!nrst) !f.vcc_ovp |=> ovp_q == 22'h0;
    endproperty
    a_ovp_restart: assert property (p_ovp_restart) else $error("overvoltage interval not restarted");
    property p_temp_restart;
        @(posedge clk_sys) disable iff (!nrst) !f.over_temp |=> temp_q == 22'h0;
    endproperty
    a_temp_restart: assert property (p_temp_restart) else $error("temperature filter not restarted");
    property p_ext_ignore;
        @(posedge clk_sys) disable iff (!nrst) (mode_q == ST_STARTUP || mode_q == ST_RESTART) |-> !ext_latch;
    endproperty
    a_ext_ignore: assert property (p_ext_ignore) else $error("pulled pin acted on at start-up");
    property p_cell_latched;
        @(posedge clk_sys) disable iff (!nrst) mode_q == ST_LATCHED && f.vcc_uv |=> ctrl_out.startup_cell_on;
    endproperty
    a_cell_latched: assert property (p_cell_latched) else $error("cell off under lockout");
    property p_ar_blocked;
        @(posedge clk_sys) disable iff (!nrst) mode_q == ST_AR_WAIT && !f.bl_charged && spike_q == 22'h0
            && !f.vcc_uv && !latch_trig && !f.vcc_rst |=> mode_q == ST_AR_WAIT;
    endproperty
    a_ar_blocked: assert property (p_ar_blocked) else $error("restart before pin charged");
endmodule : smpc_ctrl

// [smpc_pkg.sv]
// Package for the mode and protection control unit
package smpc_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned NS_PER_CLK = 1_000_000_000 / CLK_HZ;
    localparam int unsigned BLANK_MS = 20;
    localparam int unsigned SPIKE_US = 25;
    localparam int unsigned OVP_US = 120;
    localparam int unsigned SHORT_NS = 190;
    localparam int unsigned LATCH_DLY_MS = 2;
    localparam int unsigned BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
    localparam int unsigned SPIKE_CYC = SPIKE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OVP_CYC = OVP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SHORT_CYC = (SHORT_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    localparam int unsigned LATCH_DLY_CYC = LATCH_DLY_MS * (CLK_HZ / 1000);

    // Wishbone register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_ID = 4'h8;
    localparam logic [31:0] ID_VALUE = 32'h0000A5C3; // Arbitrary value
    localparam int unsigned CTRL_LATCH_EN_BIT = 0;
    localparam int unsigned CTRL_BURST_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    typedef enum logic [2:0] {
        ST_STARTUP = 3'b000,
        ST_NORMAL = 3'b001,
        ST_BURST = 3'b010,
        ST_AR_WAIT = 3'b011,
        ST_RESTART = 3'b100,
        ST_LATCHED = 3'b101
    } smpc_mode_e;

    typedef struct packed {
        logic fb_low;        // Feedback below 1.23 V
        logic fb_high;       // Feedback above 4.2 V
        logic fb_wake;       // Feedback above 3.5 V
        logic fb_sleep;      // Feedback at or below 3.0 V
        logic bl_charged;    // Blanking pin reached 4.0 V
        logic bl_pulled;     // Blanking pin below 0.33 V
        logic cs_short;      // Current sense above 1.66 V
        logic vcc_ovp;       // Supply above 25.5 V
        logic vcc_uv;        // Supply below 10.5 V
        logic vcc_on;        // Supply above 18 V
        logic vcc_rst;       // Supply below 6.23 V
        logic over_temp;     // Above thermal shutdown threshold
        logic softstart_done; // Start-up completed
    } smpc_flags_s;

    typedef struct packed {
        logic bias_en;
        logic burst_limit_sel;
        logic blanking_clamp_switch;
        logic startup_cell_on;
        logic switching_en;
        logic burst_flag;
        logic latched_off;
        logic auto_restart;
    } smpc_ctrl_s;
endpackage : smpc_pkg

// [smpc_plant.sv]
// Far-side model: passes commanded supply and feedback levels through, models the blanking pin capacitor
`timescale 1ns/1ns
module smpc_plant #(
    parameter int unsigned CHARGE_CYCLES = 100
) (
    input wire logic clk_sys,               // Time base
    input wire logic nrst,                  // Reset, active low
    input wire smpc_pkg::smpc_ctrl_s ctrl,  // Device controls
    input wire smpc_pkg::smpc_flags_s env,  // Commanded conditions
    output smpc_pkg::smpc_flags_s flags     // Comparator levels to device
);
    import smpc_pkg::*;
    logic [7:0] chg_q;
    // Capacitor charges only once the clamp lets go; a pulled-down pin never does
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            chg_q <= 8'h00;
        else if (ctrl.blanking_clamp_switch || env.bl_pulled)
            chg_q <= 8'h00;
        else if (chg_q < 8'(CHARGE_CYCLES))
            chg_q <= chg_q + 8'h01;
    end
    always_comb
    begin
        flags = env;
        flags.bl_charged = (chg_q >= 8'(CHARGE_CYCLES));
    end
endmodule : smpc_plant

// [tb_top.sv]
// Self-checking bench for the mode and protection control unit
`timescale 1ns/1ns
module tb_top;
    import smpc_pkg::*;
    logic clk_sys;
    logic nrst;
    smpc_flags_s env;
    smpc_flags_s flags;
    smpc_ctrl_s ctrl;
    logic cyc, stb, we, ack;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, d;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int bits[4] = '{1, 5, 6, 7};

    smpc_ctrl #(.BLANK_CYCLES(50), .LATCH_DLY_CYCLES(20)) smpc_ctrl_i (.clk_sys(clk_sys), .nrst(nrst),
        .flags_in(flags), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ctrl_out(ctrl));
    smpc_plant #(.CHARGE_CYCLES(100)) smpc_plant_i (.clk_sys(clk_sys), .nrst(nrst), .ctrl(ctrl),
        .env(env), .flags(flags));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : hold

    // Classic cycle; entered just after an edge, read data kept in d
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= v;
        do
            @(posedge clk_sys);
        while (ack !== 1'b1);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask : wb

    task automatic mode_is(input logic [2:0] m);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, ADDR_STAT, 4'hF, 32'h0);
            n++;
        end
        while (d[2:0] !== m && n < 400);
        chk(32'(d[2:0]), 32'(m));
    endtask : mode_is

    task automatic until_bit(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (ctrl[b] !== v && n < lim)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(ctrl[b]), 32'(v));
    endtask : until_bit

    initial
    begin
        nrst = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h0;
        env = '0;
        hold(8);
        chk(32'(ctrl), 32'h0);
        nrst <= 1'b1;
        hold(1);
        wb(1'b0, ADDR_CTRL, 4'hF, 32'h0);
        chk(d, 32'h3);
        wb(1'b0, ADDR_ID, 4'hF, 32'h0);
        chk(d, ID_VALUE);
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk(d, 32'h0);
        wb(1'b1, ADDR_CTRL, 4'hE, 32'h0);
        wb(1'b0, ADDR_CTRL, 4'hF, 32'h0);
        chk(d, 32'h3);
        wb(1'b1, ADDR_CTRL, 4'h1, 32'h2);
        wb(1'b0, ADDR_CTRL, 4'hF, 32'h0);
        chk(d, 32'h2);
        wb(1'b1, ADDR_CTRL, 4'h1, 32'h3);
        $display("Test registers done");
        env.vcc_on <= 1'b1;
        env.fb_high <= 1'b1;
        hold(200);
        chk(32'(ctrl.auto_restart), 32'h0);
        mode_is(ST_STARTUP);
        env.fb_high <= 1'b0;
        env.softstart_done <= 1'b1;
        mode_is(ST_NORMAL);
        $display("Test start-up done");
        env.fb_low <= 1'b1;
        hold(30);
        env.fb_low <= 1'b0;
        hold(60);
        chk(32'(ctrl.burst_flag), 32'h0);
        env.fb_low <= 1'b1;
        hold(40);
        chk(32'(ctrl.burst_flag), 32'h0);
        until_bit(2, 1'b1, 30);
        chk(32'(ctrl.bias_en), 32'h0);
        chk(32'(ctrl.burst_limit_sel), 32'h1);
        chk(32'(ctrl.startup_cell_on), 32'h0);
        env.fb_low <= 1'b0;
        env.fb_wake <= 1'b1;
        until_bit(7, 1'b1, 20);
        chk(32'(ctrl.startup_cell_on), 32'h0);
        env.fb_wake <= 1'b0;
        env.fb_sleep <= 1'b1;
        hold(10);
        chk(32'(ctrl.bias_en), 32'h0);
        chk(32'(ctrl.burst_flag), 32'h1);
        env.fb_sleep <= 1'b0;
        env.fb_high <= 1'b1;
        hold(10);
        chk(32'(ctrl.burst_limit_sel), 32'h0);
        env.fb_high <= 1'b0;
        mode_is(ST_NORMAL);
        $display("Test burst done");
        env.fb_high <= 1'b1;
        until_bit(5, 1'b0, 80);
        hold(90);
        chk(32'(ctrl.auto_restart), 32'h0);
        hold(200);
        chk(32'(ctrl.auto_restart), 32'h0);
        until_bit(0, 1'b1, 100);
        env.fb_high <= 1'b0;
        mode_is(ST_NORMAL);
        chk(32'(ctrl.switching_en), 32'h1);
        $display("Test auto restart done");
        // Short glitch must not latch
        env.over_temp <= 1'b1;
        hold(100);
        env.over_temp <= 1'b0;
        hold(300);
        chk(32'(ctrl.latched_off), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            env[bits[i]] <= 1'b1;
            until_bit(1, 1'b1, 1500);
            env[bits[i]] <= 1'b0;
            env.vcc_uv <= 1'b1;
            env.vcc_on <= 1'b0;
            hold(10);
            chk(32'(ctrl.startup_cell_on), 32'h1);
            env.vcc_uv <= 1'b0;
            env.vcc_on <= 1'b1;
            hold(10);
            chk(32'(ctrl.startup_cell_on), 32'h0);
            chk(32'(ctrl.switching_en), 32'h0);
            mode_is(ST_LATCHED);
            env.vcc_rst <= 1'b1;
            hold(10);
            env.vcc_rst <= 1'b0;
            mode_is(ST_NORMAL);
        end
        // Pulled pin during start-up is ignored, then acted on once running
        env.softstart_done <= 1'b0;
        env.vcc_rst <= 1'b1;
        hold(10);
        env.vcc_rst <= 1'b0;
        env.bl_pulled <= 1'b1;
        hold(100);
        chk(32'(ctrl.latched_off), 32'h0);
        env.softstart_done <= 1'b1;
        until_bit(1, 1'b1, 100);
        $display("Test latched off done");
        end_sim();
    end
endmodule : tb_top
